// [rtl/power_pwm_generator.sv]
// Power PWM generator channel: time base, duty, modes, faults, triggers
`timescale 1ns/1ps
`default_nettype none
module power_pwm_generator
	import pwm_pkg::*;
(
	input  wire logic      CLK,                     // Clock, 25 MHz
	input  wire logic      RESET,                   // Async reset, high
	input  wire logic      ENABLE,                  // Global module enable
	input  wire logic [2:0] input_clock_prescale,   // Divide by 2^n
	input  wire chan_cfg_s CHAN_CFG,                // Channel options
	input  wire out_cfg_s  OUT_CFG,                 // Output options
	input  wire trig_cfg_s TRIG_CFG,                // Trigger shaping
	input  wire count_t    PERIOD,                  // Channel period
	input  wire count_t    MASTER_PERIOD,           // Master period
	input  wire count_t    channel_duty,            // Channel duty
	input  wire count_t    MASTER_DUTY,             // Master duty
	input  wire count_t    channel_phase,           // Phase load value
	input  wire count_t    dead_time_value,         // Normal dead time
	input  wire count_t    alternate_dead_time,     // Fault dead time
	input  wire logic      EXT_RESET,               // External period reset
	input  wire logic      CL_EVENT,                // Current-limit input
	input  wire logic      FAULT,                   // Fault input
	input  wire count_t    primary_trigger_compare, // Primary compare
	input  wire count_t    secondary_trigger_compare, // Secondary compare
	output logic           high_side_output,        // High gate drive
	output logic           low_side_output,         // Low gate drive
	output logic           TRIG_OUT,                // Primary trigger pulse
	output logic           STRIG_OUT                // Secondary trigger pulse
);

	typedef struct packed {
		logic [6:0] presc;
		logic       tick;
		count_t     count;
		count_t     duty;
		count_t     period;
		logic       pp_sel;
		logic       fresh;
		logic       run;
		logic [1:0] ovr_en;
		logic [1:0] ovr_data;
		logic [3:0] div_cnt;
		logic [5:0] start_cnt;
		logic       trig;
		logic       strig;
	} gen_s;

	function automatic logic [6:0] presc_mask(input logic [2:0] sel);
		presc_mask = (7'h01 << sel) - 7'h01;
	endfunction : presc_mask

	function automatic logic [1:0] swap_pair(input logic [1:0] p,
		input logic sw);
		swap_pair = sw ? {p[0], p[1]} : p;
	endfunction : swap_pair

	gen_s       s;
	gen_s       next_s;
	count_t     per_src;
	count_t     duty_src;
	count_t     period_eff;
	count_t     dt_sel;
	logic       rollover;
	logic       xreset;
	logic       boundary;
	logic       raw;
	logic       cl_act;
	logic       fault_act;
	logic       excl;
	logic [1:0] mode_pair;
	logic [1:0] want;
	logic [1:0] pins;

	always_comb begin
		next_s = s;
		per_src = CHAN_CFG.tb_sel ? PERIOD : MASTER_PERIOD;
		duty_src = CHAN_CFG.duty_sel ? MASTER_DUTY : channel_duty; // RULE4
		period_eff = CHAN_CFG.imm_period ? per_src : s.period;
		// One rollover per period even if period shrinks below count
		rollover = s.run && s.tick && (s.count >= period_eff); // RULE17
		xreset = s.run && CHAN_CFG.ext_reset_en && EXT_RESET; // RULE12
		boundary = rollover || xreset;
		next_s.run = ENABLE;
		next_s.fresh = 1'b0;
		next_s.trig = 1'b0;
		next_s.strig = 1'b0;
		if (!ENABLE) begin
			next_s.presc = PRESC_RESET;
			next_s.tick = 1'b0;
			next_s.count = COUNT_RESET;
			next_s.start_cnt = START_RESET;
			next_s.div_cnt = DIV_RESET;
		end else begin
			// Prescaled tick sets count resolution
			next_s.tick = s.presc >= presc_mask(input_clock_prescale); // RULE14
			next_s.presc = next_s.tick ? PRESC_RESET : s.presc + 7'h01;
			if (!s.run) begin
				next_s.count = COUNT_RESET;
				next_s.duty = duty_src;
				next_s.period = per_src;
				next_s.fresh = 1'b1;
			end else if (boundary) begin
				// Duty and count change together: no stray pulse
				next_s.count = channel_phase; // RULE11 RULE12
				next_s.period = per_src;
				next_s.duty = duty_src; // RULE5 RULE6
				next_s.fresh = 1'b1;
				if (rollover) begin
					next_s.pp_sel = ~s.pp_sel; // RULE17
				end
			end else if (s.tick) begin
				next_s.count = s.count + 16'h0001;
				next_s.fresh = 1'b1;
			end
			if (CHAN_CFG.imm_update) begin
				next_s.duty = duty_src; // RULE5 RULE7
			end
		end
		// Override latch: at once, or at the period boundary
		if (!OUT_CFG.ovr_sync || boundary) begin
			next_s.ovr_en = OUT_CFG.ovr_en; // RULE9
			next_s.ovr_data = OUT_CFG.override_data; // RULE9
		end
		// Trigger compares on every freshly loaded count
		if (s.fresh && s.count == primary_trigger_compare) begin
			if (s.start_cnt < TRIG_CFG.postscaler_start_select) begin
				next_s.start_cnt = s.start_cnt + 6'h01; // RULE15
			end else if (s.div_cnt >= TRIG_CFG.trigger_output_divider) begin
				next_s.div_cnt = DIV_RESET;
				next_s.trig = 1'b1; // RULE15
			end else begin
				next_s.div_cnt = s.div_cnt + 4'h1;
			end
		end
		next_s.strig = s.fresh && s.count == secondary_trigger_compare; // RULE15
	end

	always_comb begin
		raw = s.run && (s.count < s.duty); // RULE6
		case (OUT_CFG.output_mode_field)
			MODE_COMP: begin
				mode_pair = {raw, ~raw}; // RULE2
			end
			MODE_REDUNDANT: begin
				mode_pair = {raw, raw}; // RULE3
			end
			MODE_PUSHPULL: begin
				mode_pair = {raw & ~s.pp_sel, raw & s.pp_sel}; // RULE3 RULE17
			end
			default: begin
				mode_pair = {raw, 1'b0};
			end
		endcase
		if (!s.run) begin
			mode_pair = PAIR_RESET;
		end
		cl_act = OUT_CFG.cl_en && CL_EVENT;
		fault_act = OUT_CFG.fault_en && FAULT;
		// Swap acts on the generator pair, pin forcing after it
		want = swap_pair(mode_pair, OUT_CFG.swap);
		want = (want & ~s.ovr_en) | (s.ovr_data & s.ovr_en);
		if (fault_act) begin
			want = OUT_CFG.fault_data;
		end else if (cl_act) begin
			want = OUT_CFG.cl_data; // RULE1
		end
		excl = OUT_CFG.output_mode_field == MODE_COMP && s.ovr_en == PAIR_RESET
			&& !fault_act && !cl_act;
		dt_sel = (fault_act || cl_act) ? alternate_dead_time : dead_time_value; // RULE13
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Unforced and forced pin paths both pass through dead time
	pwm_dead_time pwm_dead_time_inst (
		.clk   (CLK),
		.reset (RESET),
		.tick  (s.tick),
		.excl  (excl),
		.want  (want),
		.dt    (dt_sel),
		.out   (pins)
	);

	assign high_side_output = pins[1];
	assign low_side_output = pins[0];
	assign TRIG_OUT = s.trig;
	assign STRIG_OUT = s.strig;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence s_pp_roll;
		rollover && OUT_CFG.output_mode_field == MODE_PUSHPULL;
	endsequence

	sequence s_ext_restart;
		xreset && !rollover;
	endsequence

	a_cl_force_low: assert property (cl_act && !fault_act && !OUT_CFG.cl_data[1]
		|=> !high_side_output) // RULE1
		else $error("current limit did not clear high output");
	a_redundant_pair: assert property (OUT_CFG.output_mode_field == MODE_REDUNDANT
		&& s.run |-> mode_pair[1] == mode_pair[0]) // RULE3
		else $error("redundant outputs differ");
	a_duty_boundary: assert property (s.run && boundary && ENABLE
		|=> s.duty == $past(duty_src)) // RULE4
		else $error("duty not loaded at boundary");
	a_duty_held: assert property (s.run && ENABLE && !boundary
		&& !CHAN_CFG.imm_update |=> s.duty == $past(s.duty)) // RULE5
		else $error("duty changed inside period");
	a_zero_no_pulse: assert property ($past(s.duty) == COUNT_RESET // RULE6
		&& $past(OUT_CFG.output_mode_field) != MODE_COMP
		&& $past(s.ovr_en) == PAIR_RESET && !$past(fault_act)
		&& !$past(cl_act) |-> pins == PAIR_RESET)
		else $error("pulse with zero duty");
	a_ovr_async: assert property (!OUT_CFG.ovr_sync
		|=> s.ovr_en == $past(OUT_CFG.ovr_en)) // RULE9
		else $error("override not taken next clock");
	a_ext_restart: assert property (s_ext_restart ##0 ENABLE
		|=> s.count == $past(channel_phase)) // RULE12
		else $error("external reset did not restart time base");
	a_pp_alternate: assert property (s_pp_roll ##0 ENABLE
		|=> s.pp_sel != $past(s.pp_sel) ##1 !rollover) // RULE17
		else $error("push-pull did not alternate once");
	a_tick_spacing: assert property (s.tick && input_clock_prescale != 3'h0
		&& $stable(input_clock_prescale) |=> !s.tick) // RULE14
		else $error("prescaled tick too frequent");

endmodule : power_pwm_generator
`default_nettype wire

// [rtl/pwm_dead_time.sv]
// Dead-time inserter for the output pair, registered outputs
`timescale 1ns/1ps
`default_nettype none
module pwm_dead_time
	import pwm_pkg::*;
(
	input  wire logic       clk,    // Clock
	input  wire logic       reset,  // Async reset, high
	input  wire logic       tick,   // Prescaled count tick
	input  wire logic       excl,   // Pair must never overlap
	input  wire logic [1:0] want,   // Wanted {high, low}
	input  wire count_t     dt,     // Dead time in ticks
	output logic      [1:0] out     // Pin levels {high, low}
);

	typedef struct packed {
		logic [1:0] out;
		logic [1:0] prev;
		count_t     cnt;
		count_t     low_ticks;
	} dt_s;

	dt_s s;
	dt_s next_s;

	always_comb begin
		next_s = s;
		// Falling edges pass at once, rising edges wait
		next_s.out = s.out & want; // RULE1
		if ((want & ~s.out) != PAIR_RESET) begin
			// Count restarts on every change of the wanted pair
			if (want == s.prev && s.cnt >= dt) begin
				next_s.out = want; // RULE2 RULE7 RULE13
			end else if (tick) begin
				next_s.cnt = s.cnt + 16'h0001;
			end
		end
		next_s.prev = want;
		if (want != s.prev) begin
			next_s.cnt = COUNT_RESET;
		end
		if (s.out != PAIR_RESET) begin
			next_s.low_ticks = COUNT_RESET;
		end else if (tick && s.low_ticks != 16'hffff) begin
			next_s.low_ticks = s.low_ticks + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign out = s.out;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_no_overlap: assert property (excl && $past(excl) |-> !(s.out[1] && s.out[0])) // RULE2
		else $error("complementary outputs overlap");
	a_full_dead: assert property ($rose(s.out[1] || s.out[0]) && $past(excl)
		|-> $past(s.low_ticks) >= $past(dt)) // RULE13
		else $error("dead time shorter than programmed");
	a_fast_off: assert property (s.out[1] && !want[1] |=> !s.out[1]) // RULE1
		else $error("high output not dropped next cycle");

endmodule : pwm_dead_time
`default_nettype wire

// [rtl/pwm_pkg.sv]
// Constants and carrier types for the power PWM generator channel
// Operation
// [RULE1] Current limit forces outputs with least latency
// [RULE2] Complementary low output inverted, dead time, no glitch
// [RULE3] Mode code 01 redundant, 10 push-pull
// [RULE4] Select bit picks own or master duty
// [RULE5] Immediate update applies duty now, else boundary
// [RULE6] Duty to zero gives no boundary pulse
// [RULE7] Immediate duty transition still gets full dead time
// [RULE8] Software sets immediate update before module enable
// [RULE9] Unsynchronised override applies on next clock
// [RULE10] Software may override low for zero duty
// [RULE11] Phase change keeps dead time at master rollover
// [RULE12] External reset restarts time base, also swapped
// [RULE13] Alternate dead time applied in full always
// [RULE14] Three-bit prescaler sets count resolution
// [RULE15] Trigger compares fire on first match, divided
// [RULE16] Software keeps trigger compares at eight or more
// [RULE17] Push-pull keeps one pulse per period
// [RULE18] Software writes period away from rollover
package pwm_pkg;

	typedef logic [15:0] count_t;

	localparam logic [1:0] MODE_COMP      = 2'h0;
	localparam logic [1:0] MODE_REDUNDANT = 2'h1;
	localparam logic [1:0] MODE_PUSHPULL  = 2'h2;
	localparam logic [1:0] MODE_INDEP     = 2'h3;

	localparam logic [6:0] PRESC_RESET = 7'h00;
	localparam count_t     COUNT_RESET = 16'h0000;
	localparam logic [3:0] DIV_RESET   = 4'h0;
	localparam logic [5:0] START_RESET = 6'h00;
	localparam logic [1:0] PAIR_RESET  = 2'h0;

	// Channel timing options
	typedef struct packed {
		logic duty_sel;      // 1: master duty
		logic imm_update;    // Duty applies at once
		logic imm_period;    // Period applies at once
		logic tb_sel;        // 0: master period
		logic ext_reset_en;  // External period reset enable
	} chan_cfg_s;

	// Output pair options
	typedef struct packed {
		logic [1:0] output_mode_field;
		logic       swap;
		logic       ovr_sync;    // 1: override at period boundary
		logic [1:0] ovr_en;      // {high, low}
		logic [1:0] override_data;
		logic       cl_en;
		logic [1:0] cl_data;
		logic       fault_en;
		logic [1:0] fault_data;
	} out_cfg_s;

	// Trigger shaping
	typedef struct packed {
		logic [3:0] trigger_output_divider;
		logic [5:0] postscaler_start_select;
	} trig_cfg_s;

endpackage : pwm_pkg

// [sim/gate_driver_model.sv]
// Gate driver and switch pair model watching the output pair
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
	input  wire logic        clk,     // Clock
	input  wire logic        clr,     // Clear statistics
	input  wire logic        hi,      // High gate drive
	input  wire logic        lo,      // Low gate drive
	output logic             overlap, // Both switches seen on
	output logic      [15:0] min_gap  // Shortest off gap, cycles
);
	logic [15:0] run;
	logic        last;
	always @(posedge clk) begin
		if (clr) begin
			overlap <= 1'h0;
			min_gap <= 16'hffff;
			run <= 16'h0000;
			last <= 1'h0;
		end else begin
			if (hi && lo)
				overlap <= 1'h1;
			if (hi || lo) begin
				// Gap counts only when the other switch takes over
				if (last != hi && run < min_gap)
					min_gap <= run;
				run <= 16'h0000;
				last <= hi;
			end else
				run <= run + 16'h0001;
		end
	end
endmodule : gate_driver_model
`default_nettype wire

// [sim/power_pwm_generator_tb.sv]
// Self-checking testbench for the power PWM generator channel
`timescale 1ns/1ps
`default_nettype none
module power_pwm_generator_tb
	import pwm_pkg::*;
;
	logic CLK = 1'h0, RESET = 1'h1, ENABLE = 1'h0, EXT_RESET = 1'h0;
	logic CL_EVENT = 1'h0, FAULT = 1'h0, clr = 1'h1;
	logic [2:0] input_clock_prescale = 3'h0;
	chan_cfg_s CHAN_CFG = 5'h06;
	out_cfg_s OUT_CFG = 15'h0000;
	trig_cfg_s TRIG_CFG = {4'h1, 6'h00};
	count_t PERIOD = 16'h0009, MASTER_PERIOD = 16'h0014;
	count_t channel_duty = 16'h0004, MASTER_DUTY = 16'h0003;
	count_t channel_phase = 16'h0000, dead_time_value = 16'h0000;
	count_t alternate_dead_time = 16'h0000;
	count_t primary_trigger_compare = 16'h0008;
	count_t secondary_trigger_compare = 16'h0009;
	logic high_side_output, low_side_output, TRIG_OUT, STRIG_OUT, overlap;
	logic [15:0] min_gap;
	logic [31:0] seed = 32'h0000003a, p, d, w, hi, lo, tr, st;
	logic [2:0] n;
	int fail_count = 0, checked = 0, cycles = 0;

	power_pwm_generator power_pwm_generator_inst (.CLK, .RESET, .ENABLE,
		.input_clock_prescale, .CHAN_CFG, .OUT_CFG, .TRIG_CFG, .PERIOD,
		.MASTER_PERIOD, .channel_duty, .MASTER_DUTY, .channel_phase,
		.dead_time_value, .alternate_dead_time, .EXT_RESET, .CL_EVENT,
		.FAULT, .primary_trigger_compare, .secondary_trigger_compare,
		.high_side_output, .low_side_output, .TRIG_OUT, .STRIG_OUT);
	gate_driver_model gate_driver_model_inst (.clk(CLK), .clr,
		.hi(high_side_output), .lo(low_side_output), .overlap, .min_gap);

	always #20 CLK = ~CLK;

	task automatic report_and_stop;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [31:0] rnd(input logic [31:0] lim);
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed % lim;
	endfunction : rnd

	// On-cycles of one side over four whole periods, zero dead time
	function automatic logic [31:0] exp_on(input logic [1:0] m,
		input logic side, input logic [31:0] dd, pp, input logic [2:0] nn);
		logic [31:0] wh, wl;
		wh = (dd << nn) - 32'h1;
		wl = ((pp + 32'h1 - dd) << nn) - 32'h1;
		case (m)
			MODE_COMP:      return 32'h4 * (side ? wh : wl);
			MODE_REDUNDANT: return 32'h4 * wh;
			MODE_PUSHPULL:  return 32'h2 * wh;
			default:        return side ? 32'h4 * wh : 32'h0;
		endcase
	endfunction : exp_on

	task automatic measure(input logic [31:0] skip, input logic [31:0] k);
		repeat (skip) @(negedge CLK);
		{hi, lo, tr, st} = '0;
		repeat (k) begin
			@(negedge CLK);
			hi = hi + 32'(high_side_output);
			lo = lo + 32'(low_side_output);
			tr = tr + 32'(TRIG_OUT);
			st = st + 32'(STRIG_OUT);
		end
	endtask : measure

	// Restart the channel with a fresh mode, duty and prescale
	task automatic run_pwm(input logic [1:0] m, input count_t dd,
		input logic [2:0] nn);
		@(negedge CLK);
		ENABLE = 1'h0;
		OUT_CFG.output_mode_field = m;
		channel_duty = dd;
		input_clock_prescale = nn;
		@(negedge CLK);
		ENABLE = 1'h1;
	endtask : run_pwm

	initial begin
		repeat (5) @(negedge CLK);
		check(32'({high_side_output, low_side_output}), 32'h0);
		RESET = 1'h0;
		for (int i = 0; i < 4; i++) begin
			p = 32'h9 + rnd(32'h7);
			d = 32'h2 + rnd(p - 32'h3);
			n = 3'(rnd(32'h2));
			PERIOD = p[15:0];
			TRIG_CFG.postscaler_start_select = 6'(i);
			run_pwm(2'(i), d[15:0], n);
			w = (p + 32'h1) << n;
			measure(32'h1, 4 * w);
			check(tr, (32'h4 - 32'(i)) >> 1);
			check(st, 32'h4);
			measure(32'h0, 4 * w);
			check(hi, exp_on(2'(i), 1'h1, d, p, n));
			check(lo, exp_on(2'(i), 1'h0, d, p, n));
		end
		w = p + 32'h1;
		CHAN_CFG.duty_sel = 1'h1;
		run_pwm(MODE_COMP, 16'h0005, 3'h0);
		measure(4 * w, 4 * w);
		check(hi, exp_on(MODE_COMP, 1'h1, 32'h3, p, 3'h0));
		CHAN_CFG.duty_sel = 1'h0;
		run_pwm(MODE_REDUNDANT, 16'h0004, 3'h0);
		measure(4 * w, w + rnd(w));
		channel_duty = 16'h0000;
		measure(3 * w, 4 * w);
		check(hi + lo, 32'h0);
		OUT_CFG.swap = 1'h1;
		CHAN_CFG.ext_reset_en = 1'h1;
		EXT_RESET = 1'h1;
		run_pwm(MODE_COMP, 16'h0004, 3'h0);
		measure(w, 2 * w);
		check(lo, 2 * w);
		check(hi, 32'h0);
		{OUT_CFG.swap, CHAN_CFG.ext_reset_en, EXT_RESET} = 3'h0;
		run_pwm(MODE_COMP, 16'h0004, 3'h0);
		measure(2 * w, rnd(w));
		OUT_CFG.ovr_en = 2'h3;
		OUT_CFG.override_data = 2'h2;
		measure(32'h3, 2 * w);
		check(hi, 2 * w);
		check(lo, 32'h0);
		OUT_CFG.ovr_en = 2'h0;
		measure(4 * w, 4 * w);
		check(hi, exp_on(MODE_COMP, 1'h1, 32'h4, p, 3'h0));
		OUT_CFG.cl_en = 1'h1;
		while (high_side_output !== 1'h1)
			@(negedge CLK);
		CL_EVENT = 1'h1;
		@(negedge CLK);
		check(32'({high_side_output, low_side_output}), 32'h0);
		{CL_EVENT, OUT_CFG.cl_en} = 2'h0;
		alternate_dead_time = 16'h0258;
		OUT_CFG.fault_en = 1'h1;
		OUT_CFG.fault_data = 2'h2;
		run_pwm(MODE_COMP, 16'h0000, 3'h0);
		measure(4 * w, 32'h0);
		FAULT = 1'h1;
		measure(32'd590, 32'h0);
		check(32'(high_side_output), 32'h0);
		measure(32'd20, 32'h0);
		check(32'(high_side_output), 32'h1);
		{FAULT, OUT_CFG.fault_en} = 2'h0;
		CHAN_CFG.tb_sel = 1'h0;
		dead_time_value = 16'h0004;
		for (int j = 0; j < 2; j++) begin
			CHAN_CFG.imm_update = 1'(j);
			run_pwm(MODE_COMP, 16'h000a, 3'h0);
			@(negedge CLK);
			clr = 1'h0;
			repeat (40) begin
				measure(32'h0, 32'h3 + rnd(32'h6));
				channel_duty = 16'(32'h2 + rnd(32'h11));
				channel_phase = 16'(rnd(32'h7));
			end
			check(32'(overlap), 32'h0);
			check(32'(min_gap >= 16'h0004), 32'h1);
			clr = 1'h1;
		end
		report_and_stop();
	end
endmodule : power_pwm_generator_tb
`default_nettype wire
